//--- crf_pkg.sv
// constants for the communications register file access control
package crf_pkg;
    localparam int BYTES = 4;
    localparam int SEL_W = 6;
    localparam int DEST_W = 8;
    localparam int CARDS = 8;
    localparam int MAINT_W = 20;
    localparam int M_RD_LO = 0;
    localparam int M_WR_LO = 6;
    localparam int M_BS_LO = 12;
    localparam int M_LHEX = 16;
    localparam int M_RHEX = 17;
    localparam int M_WEN = 18;
    localparam int M_REN = 19;
    localparam int CARD_LO = 0;
    localparam int WORD_LO = 3;
    localparam int HALF_BIT = 6;
    localparam int BYTE_BIT = 7;
    localparam logic [SEL_W-1:0] SEL_RST = 6'h00;
endpackage

//--- crf_decode.sv
// three-to-eight one-hot decoder with enable
`timescale 1ns/10ps
`default_nettype none
module crf_decode (
    input wire logic en,
    input wire logic [2:0] sel,
    output logic [7:0] hot
);
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_dec
            assign hot[i] = en && (sel == 3'(i));
        end
    endgenerate
endmodule
`default_nettype wire

//--- crf_byte_ctl.sv
// per-byte controller: registers selects and makes card enables
`timescale 1ns/10ps
`default_nettype none
module crf_byte_ctl (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [5:0] rd_sel,
    input wire logic [5:0] wr_sel,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic byte_sel,
    input wire logic lhex,
    input wire logic rhex,
    input wire logic inhibit,
    output logic [7:0] rd_card_en,
    output logic [2:0] rd_word,
    output logic [7:0] wr_card_en,
    output logic [5:0] wr_sel_q,
    output logic wr_en_q,
    output logic byte_q,
    output logic lhex_q,
    output logic rhex_q
);
    logic [7:0] rd_hot;
    logic [7:0] wr_hot;
    wire wr_ok = wr_en_q && !inhibit && byte_q;
    crf_decode u_rd (.en(rd_en), .sel(rd_sel[2:0]), .hot(rd_hot));
    crf_decode u_wr (.en(wr_ok), .sel(wr_sel_q[2:0]), .hot(wr_hot));
    assign wr_card_en = wr_hot;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rd_card_en <= 8'h00;
            rd_word <= 3'h0;
            wr_sel_q <= crf_pkg::SEL_RST;
            wr_en_q <= 1'b0;
            byte_q <= 1'b0;
            lhex_q <= 1'b0;
            rhex_q <= 1'b0;
        end
        else if (ce)
        begin
            rd_card_en <= rd_hot;
            rd_word <= rd_sel[5:3];
            wr_sel_q <= wr_sel;
            wr_en_q <= wr_en;
            byte_q <= byte_sel;
            lhex_q <= lhex;
            rhex_q <= rhex;
        end
    end
endmodule
`default_nettype wire

//--- crf_access_ctl.sv
// access loader and four per-byte controllers for the register file
`timescale 1ns/10ps
`default_nettype none
module crf_access_ctl (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [5:0] SRC,
    input wire logic [7:0] DEST,
    input wire logic RD_VIA_DEST,
    input wire logic LOAD_VP_BASE_OP,
    input wire logic [2:0] ACTIVE_VP_CODE,
    input wire logic MAINT_SELECT,
    input wire logic [19:0] MAINT_BUS_BITS,
    input wire logic REG_ADDRESS_CTL,
    input wire logic FULLWORD_WRITE,
    input wire logic HALFWORD_WRITE,
    input wire logic BYTE_WRITE,
    input wire logic LEFT_HEX_REQ,
    input wire logic RIGHT_HEX_REQ,
    input wire logic WRITE_REQ,
    input wire logic READ_REQ,
    input wire logic FILE_INHIBIT,
    output logic [31:0] READ_CARD_ENABLES,
    output logic [11:0] READ_WORD_SEL_OUT,
    output logic [31:0] WRITE_CARD_ENABLES,
    output logic [11:0] WRITE_WORD_SEL,
    output logic [23:0] WRITE_SEL_STATUS,
    output logic [3:0] WRITE_EN_STATUS,
    output logic [3:0] BYTE_EN_STATUS,
    output logic [3:0] WRITE_LEFT_HEX,
    output logic [3:0] WRITE_RIGHT_HEX
);
    // read select: destination for indirect and bit-test ops
    wire [5:0] norm_rd = RD_VIA_DEST ? DEST[5:0] : SRC;
    wire [5:0] read_card_word_sel = MAINT_SELECT ?
        MAINT_BUS_BITS[crf_pkg::M_RD_LO +: 6] : norm_rd;
    wire [2:0] norm_word = LOAD_VP_BASE_OP ? ACTIVE_VP_CODE : DEST[5:3];
    wire [5:0] norm_wr = {norm_word, DEST[2:0]};
    wire [5:0] write_card_word_sel = MAINT_SELECT ?
        MAINT_BUS_BITS[crf_pkg::M_WR_LO +: 6] : norm_wr;
    wire d6 = DEST[crf_pkg::HALF_BIT];
    wire d7 = DEST[crf_pkg::BYTE_BIT];
    wire [3:0] half_sel = d6 ? 4'hc : 4'h3;
    wire [3:0] one_sel = 4'(4'h1 << {d6, d7});
    wire [3:0] size_sel = FULLWORD_WRITE ? 4'hf :
        HALFWORD_WRITE ? half_sel : BYTE_WRITE ? one_sel : 4'h0;
    // address control gates derivation; other writes select no bytes
    wire derive_ok = REG_ADDRESS_CTL && WRITE_REQ;
    wire [3:0] derived_sel = derive_ok ? size_sel : 4'h0;
    wire [3:0] byte_sel = MAINT_SELECT ?
        MAINT_BUS_BITS[crf_pkg::M_BS_LO +: 4] : derived_sel;
    wire left_hex_ind = MAINT_SELECT ?
        MAINT_BUS_BITS[crf_pkg::M_LHEX] : LEFT_HEX_REQ;
    wire right_hex_ind = MAINT_SELECT ?
        MAINT_BUS_BITS[crf_pkg::M_RHEX] : RIGHT_HEX_REQ;
    wire file_write_en = MAINT_SELECT ?
        MAINT_BUS_BITS[crf_pkg::M_WEN] : WRITE_REQ;
    wire file_read_en = MAINT_SELECT ?
        MAINT_BUS_BITS[crf_pkg::M_REN] : READ_REQ;
    // loader outputs registered once so all controllers see one cycle
    logic [5:0] rd_q;
    logic [5:0] wr_q;
    logic [3:0] bs_q;
    logic lh_q;
    logic rh_q;
    logic we_q;
    logic re_q;
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            rd_q <= crf_pkg::SEL_RST;
            wr_q <= crf_pkg::SEL_RST;
            bs_q <= 4'h0;
            lh_q <= 1'b0;
            rh_q <= 1'b0;
            we_q <= 1'b0;
            re_q <= 1'b0;
        end
        else if (CE)
        begin
            rd_q <= read_card_word_sel;
            wr_q <= write_card_word_sel;
            bs_q <= byte_sel;
            lh_q <= left_hex_ind;
            rh_q <= right_hex_ind;
            we_q <= file_write_en;
            re_q <= file_read_en;
        end
    end
    logic [7:0] wce [4];
    logic [5:0] wsq [4];
    genvar b;
    generate
        for (b = 0; b < 4; b++)
        begin : g_byte
            crf_byte_ctl u_ctl (
                .clk(CLK),
                .rst(RST),
                .ce(CE),
                .rd_sel(rd_q),
                .wr_sel(wr_q),
                .rd_en(re_q),
                .wr_en(we_q),
                .byte_sel(bs_q[b]),
                .lhex(lh_q),
                .rhex(rh_q),
                .inhibit(FILE_INHIBIT),
                .rd_card_en(READ_CARD_ENABLES[8*b +: 8]),
                .rd_word(READ_WORD_SEL_OUT[3*b +: 3]),
                .wr_card_en(wce[b]),
                .wr_sel_q(wsq[b]),
                .wr_en_q(WRITE_EN_STATUS[b]),
                .byte_q(BYTE_EN_STATUS[b]),
                .lhex_q(WRITE_LEFT_HEX[b]),
                .rhex_q(WRITE_RIGHT_HEX[b])
            );
            assign WRITE_CARD_ENABLES[8*b +: 8] = wce[b];
            assign WRITE_SEL_STATUS[6*b +: 6] = wsq[b];
            assign WRITE_WORD_SEL[3*b +: 3] = wsq[b][5:3];
        end
    endgenerate

    logic [1:0] past_ok;
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            past_ok <= 2'h0;
        else
            past_ok <= {past_ok[0], 1'b1};
    end

    maint_read_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && MAINT_SELECT) |=> rd_q == $past(MAINT_BUS_BITS[5:0]))
        else $error("maint read select");
    fullword_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && !MAINT_SELECT && REG_ADDRESS_CTL && WRITE_REQ &&
        FULLWORD_WRITE) |=> bs_q == 4'hf)
        else $error("fullword select");
    halfword_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && !MAINT_SELECT && REG_ADDRESS_CTL && WRITE_REQ &&
        !FULLWORD_WRITE && HALFWORD_WRITE)
        |=> bs_q == ($past(DEST[6]) ? 4'hc : 4'h3))
        else $error("halfword select");
    freeze_a: assert property (@(posedge CLK) disable iff (RST)
        !CE |=> (bs_q == $past(bs_q) && rd_q == $past(rd_q) &&
        wr_q == $past(wr_q)))
        else $error("state moved while frozen");
    addr_gate_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && !MAINT_SELECT && !REG_ADDRESS_CTL) |=> bs_q == 4'h0)
        else $error("byte select without address control");
    maint_bytes_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && MAINT_SELECT) |=> bs_q == $past(MAINT_BUS_BITS[15:12]))
        else $error("maint byte select");
    vp_base_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && !MAINT_SELECT && LOAD_VP_BASE_OP)
        |=> wr_q[5:3] == $past(ACTIVE_VP_CODE))
        else $error("vp base word select");
    read_card_a: assert property (@(posedge CLK) disable iff (RST)
        (CE && re_q) |=>
        READ_CARD_ENABLES[7:0] == 8'(8'h1 << $past(rd_q[2:0])))
        else $error("read card decode");
    same_cycle_a: assert property (@(posedge CLK) disable iff (RST)
        past_ok[1] |-> READ_CARD_ENABLES[7:0] == READ_CARD_ENABLES[31:24])
        else $error("byte controllers disagree");
    write_gate_a: assert property (@(posedge CLK) disable iff (RST)
        (FILE_INHIBIT || !WRITE_EN_STATUS[0] || !BYTE_EN_STATUS[0])
        |-> WRITE_CARD_ENABLES[7:0] == 8'h00)
        else $error("write enable without permission");
endmodule
`default_nettype wire

//--- crf_ctl_model.sv
// instruction control and maintenance source model facing the access control
`timescale 1ns/10ps
`default_nettype none
module crf_ctl_model (
    input wire logic clk,
    output logic ce,
    output logic [5:0] src,
    output logic [7:0] dest,
    output logic rd_via,
    output logic vp_op,
    output logic [2:0] vp_code,
    output logic maint,
    output logic [19:0] mbus,
    output logic addr_ctl,
    output logic full_wr,
    output logic half_wr,
    output logic byte_wr,
    output logic lhex,
    output logic rhex,
    output logic wr_req,
    output logic rd_req,
    output logic inhibit
);
    logic [10:0] f = 11'h000;
    logic [5:0] s = 6'h00;
    logic [7:0] d = 8'h00;
    logic m = 1'b0;
    logic [19:0] mb = 20'h00000;
    logic [2:0] vp = 3'h0;
    logic c = 1'b1;
    assign ce = c;
    assign src = s;
    assign dest = d;
    assign maint = m;
    assign mbus = mb;
    assign vp_code = vp;
    assign {inhibit, rd_via, vp_op, addr_ctl, full_wr, half_wr, byte_wr,
        lhex, rhex, wr_req, rd_req} = f;
    // one request held for one clock; released data lines flip so that
    // a stale value can never pass for a held one
    task automatic issue(input logic [5:0] s_in, input logic [7:0] d_in,
        input logic [10:0] f_in, input logic m_in, input logic [19:0] mb_in,
        input logic [2:0] vp_in);
        @(negedge clk);
        s = s_in;
        d = d_in;
        f = f_in;
        m = m_in;
        mb = mb_in;
        vp = vp_in;
        @(negedge clk);
        s = ~s;
        d = ~d;
        f = f & 11'h400;
        m = 1'b0;
        mb = ~mb;
        vp = ~vp;
    endtask
    // freeze or release the block's state between requests
    task automatic hold(input logic v);
        @(negedge clk);
        c = v;
    endtask
endmodule
`default_nettype wire

//--- crf_access_ctl_bench.sv
// self-checking bench for the register file access control
`timescale 1ns/10ps
`default_nettype none
module crf_access_ctl_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    wire ce, rdv, vpo, mnt, adr, fw, hw, bw, lh, rh, wq, rq, inh;
    wire [5:0] src;
    wire [7:0] dest;
    wire [2:0] vpc;
    wire [19:0] mb;
    wire [31:0] rce, wce;
    wire [11:0] rws, wws;
    wire [23:0] wss;
    wire [3:0] wes, bes, wlh, wrh;
    int num_errors = 0;
    int n_compared = 0;
    always #12.5 clk = ~clk;
    crf_ctl_model crf_ctl_model_i (.clk(clk), .ce(ce), .src(src),
        .dest(dest), .rd_via(rdv), .vp_op(vpo), .vp_code(vpc), .maint(mnt),
        .mbus(mb), .addr_ctl(adr), .full_wr(fw), .half_wr(hw), .byte_wr(bw),
        .lhex(lh), .rhex(rh), .wr_req(wq), .rd_req(rq), .inhibit(inh));
    crf_access_ctl crf_access_ctl_i (.CLK(clk), .RST(rst), .CE(ce),
        .SRC(src), .DEST(dest), .RD_VIA_DEST(rdv), .LOAD_VP_BASE_OP(vpo),
        .ACTIVE_VP_CODE(vpc), .MAINT_SELECT(mnt), .MAINT_BUS_BITS(mb),
        .REG_ADDRESS_CTL(adr), .FULLWORD_WRITE(fw), .HALFWORD_WRITE(hw),
        .BYTE_WRITE(bw), .LEFT_HEX_REQ(lh), .RIGHT_HEX_REQ(rh),
        .WRITE_REQ(wq), .READ_REQ(rq), .FILE_INHIBIT(inh),
        .READ_CARD_ENABLES(rce), .READ_WORD_SEL_OUT(rws),
        .WRITE_CARD_ENABLES(wce), .WRITE_WORD_SEL(wws),
        .WRITE_SEL_STATUS(wss), .WRITE_EN_STATUS(wes),
        .BYTE_EN_STATUS(bes), .WRITE_LEFT_HEX(wlh), .WRITE_RIGHT_HEX(wrh));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // flag bits: inhibit, read via dest, vp base, addr ctl, full, half,
    // byte, left hex, right hex, write, read
    task automatic run(input logic [5:0] s, input logic [7:0] d,
        input logic [10:0] fl, input logic m, input logic [19:0] b,
        input logic [2:0] vp);
        logic [5:0] rs, ws;
        logic [3:0] bs, ctl;
        logic [31:0] wexp;
        crf_ctl_model_i.issue(s, d, fl, m, b, vp);
        @(posedge clk);
        #1;
        rs = m ? b[5:0] : (fl[9] ? d[5:0] : s);
        ws = m ? b[11:6] : {fl[8] ? vp : d[5:3], d[2:0]};
        ctl = m ? b[19:16] : {fl[0], fl[1], fl[2], fl[3]};
        bs = m ? b[15:12] : !(fl[7] && fl[1]) ? 4'h0 : fl[6] ? 4'hf
            : fl[5] ? (d[6] ? 4'hc : 4'h3) : fl[4] ? 4'h1 << {d[6], d[7]}
            : 4'h0;
        for (int i = 0; i < 4; i++)
            wexp[8*i +: 8] = (ctl[2] && !fl[10] && bs[i]) ? 8'h01 << ws[2:0]
                : 8'h00;
        chk(rce, {4{(ctl[3] ? 8'h01 << rs[2:0] : 8'h00)}});
        chk(rws, {4{rs[5:3]}});
        chk(wce, wexp);
        chk(wws, {4{ws[5:3]}});
        chk(wss, {4{ws}});
        chk(wes, {4{ctl[2]}});
        chk(bes, bs);
        chk(wlh, {4{ctl[0]}});
        chk(wrh, {4{ctl[1]}});
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        chk(|{rce, rws, wce, wws, wss, wes, bes, wlh, wrh}, 1'b0);
        @(negedge clk);
        rst = 1'b0;
        run(6'h00, 8'h00, 11'h000, 1'b0, 20'h0, 3'h0);
        for (int i = 0; i < 8; i++)
            run(6'(9 * i), 8'h3f, 11'h001, 1'b0, 20'h0, 3'h0);
        run(6'h2d, 8'h1a, 11'h201, 1'b0, 20'h0, 3'h0);
        run(6'h15, 8'h2b, 11'h0c3, 1'b0, 20'h0, 3'h0);
        for (int i = 0; i < 4; i++)
            run(6'h00, {i[0], i[1], 3'(i), 3'(7 - i)}, 11'h092, 1'b0,
                20'h0, 3'h0);
        run(6'h00, 8'h05, 11'h0a2, 1'b0, 20'h0, 3'h0);
        run(6'h00, 8'h45, 11'h0a2, 1'b0, 20'h0, 3'h0);
        run(6'h00, 8'h3a, 11'h1c2, 1'b0, 20'h0, 3'h5);
        run(6'h00, 8'h0e, 11'h09a, 1'b0, 20'h0, 3'h0);
        run(6'h00, 8'hd1, 11'h096, 1'b0, 20'h0, 3'h0);
        run(6'h00, 8'h13, 11'h4c2, 1'b0, 20'h0, 3'h0);
        run(6'h00, 8'h13, 11'h042, 1'b0, 20'h0, 3'h0);
        run(6'h00, 8'h13, 11'h0c0, 1'b0, 20'h0, 3'h0);
        run(6'h15, 8'hea, 11'h2c3, 1'b1, 20'hd9c5e, 3'h2);
        run(6'h2a, 8'h51, 11'h0ca, 1'b1, 20'h6a3b1, 3'h0);
        crf_ctl_model_i.hold(1'b0);
        repeat (3) @(posedge clk);
        #1;
        chk(rws, {4{3'h6}});
        chk(wss, {4{6'h0e}});
        crf_ctl_model_i.hold(1'b1);
        end_of_test();
    end
    initial
    begin
        #50000;
        num_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
